// ---- gpc_conversion_control.sv ----
// control of the general purpose converter: registers, sequencing, status
`timescale 1ns/1ps
// Functional notes
// - result is positive input minus negative input.
// - open negative input is replaced by an internal 800 mV reference.
// - enable bit must be set in the same write as busy; it powers the converter.
// - writing busy starts one conversion; busy holds while converting.
// - completion clears busy and raises the converter interrupt.
// - reading the result register clears the pending interrupt.
// - continuous bit repeats conversions automatically.
// - continuous interval comes from the period register.
// - serial status word carries interrupt pending in cell 14.
// - status cells 8 to 15 only in two-byte address formats.
module gpc_conversion_control #(
  parameter int SAMPLE_W = gpc_pkg::SAMPLE_W,
  parameter int PERIOD_W = gpc_pkg::PERIOD_W,
  parameter int CONV_CYCLES = gpc_pkg::CONV_CYCLES,
  parameter int TICK_CYCLES = gpc_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [gpc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [gpc_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [gpc_pkg::DATA_W-1:0] rdata_out,
  input wire logic [SAMPLE_W-1:0] converter_input_pos_in,
  input wire logic [SAMPLE_W-1:0] converter_input_neg_in,
  input wire logic neg_open_in,
  input wire logic long_format_in,
  output logic converter_power_out,
  output logic converter_irq_out,
  output logic [15:0] status_word_out
);
  gpc_pkg::gpc_state_t state_reg;
  gpc_pkg::gpc_state_t state_next;
  logic en_reg;
  logic continuous_sampling_bit_reg;
  logic busy_reg;
  logic pend_reg;
  logic [PERIOD_W-1:0] period_reg;
  logic [SAMPLE_W:0] result_reg;
  logic conv_done;
  logic [SAMPLE_W:0] conv_result;
  logic expire;

  function automatic logic hit(input logic [gpc_pkg::ADDR_W-1:0] a,
                               input logic [gpc_pkg::ADDR_W-1:0] b);
    hit = (a == b);
  endfunction : hit

  wire wr_ctrl = wr_in && hit(addr_in, gpc_pkg::ADDR_CTRL);
  wire wr_period = wr_in && hit(addr_in, gpc_pkg::ADDR_PERIOD);
  wire rd_result = rd_in && hit(addr_in, gpc_pkg::ADDR_RESULT);
  wire en_next = wr_ctrl ? wdata_in[gpc_pkg::CTRL_EN_BIT] : en_reg;
  wire continuous_sampling_bit_next = wr_ctrl ? wdata_in[gpc_pkg::CTRL_CONTINUOUS_SAMPLING_BIT_BIT] : continuous_sampling_bit_reg;
  // start is honoured only when the same write sets enable, and while idle
  wire start_req = wr_ctrl && wdata_in[gpc_pkg::CTRL_BUSY_BIT] &&
                   wdata_in[gpc_pkg::CTRL_EN_BIT];
  wire stop = !en_next;
  wire launch = (state_next == gpc_pkg::GPC_CONVERT) &&
                (state_reg != gpc_pkg::GPC_CONVERT);
  wire pend_next = conv_done || (pend_reg && !rd_result);
  wire [gpc_pkg::DATA_W-1:0] ctrl_word = gpc_pkg::DATA_W'({en_reg, continuous_sampling_bit_reg, busy_reg});
  wire [gpc_pkg::DATA_W-1:0] result_word = gpc_pkg::DATA_W'($signed(result_reg));

  logic [15:0] status_next;
  always_comb begin
    status_next = 16'h0000;
    status_next[gpc_pkg::STAT_READY_BIT] = 1'b1;
    status_next[gpc_pkg::STAT_PEND_BIT] = pend_next;
    // short address formats carry only the low byte
    if (!long_format_in) begin
      status_next[15:gpc_pkg::STAT_LONG_LSB] = 8'h00;
    end
  end

  logic [gpc_pkg::DATA_W-1:0] rdata_next;
  always_comb begin
    rdata_next = '0;
    if (rd_in) begin
      case (addr_in)
        gpc_pkg::ADDR_CTRL: rdata_next = ctrl_word;
        gpc_pkg::ADDR_PERIOD: rdata_next = gpc_pkg::DATA_W'(period_reg);
        gpc_pkg::ADDR_RESULT: rdata_next = result_word;
        gpc_pkg::ADDR_STATUS: rdata_next = status_next;
        default: rdata_next = '0;
      endcase
    end
  end

  always_comb begin
    state_next = state_reg;
    if (stop) begin
      state_next = gpc_pkg::GPC_IDLE;
    end else begin
      case (state_reg)
        gpc_pkg::GPC_IDLE: begin
          if (start_req) begin
            state_next = gpc_pkg::GPC_CONVERT;
          end
        end
        gpc_pkg::GPC_CONVERT: begin
          if (conv_done) begin
            state_next = gpc_pkg::GPC_DONE;
          end
        end
        gpc_pkg::GPC_DONE: begin
          state_next = continuous_sampling_bit_next ? gpc_pkg::GPC_WAIT : gpc_pkg::GPC_IDLE;
        end
        gpc_pkg::GPC_WAIT: begin
          if (!continuous_sampling_bit_next) begin
            state_next = gpc_pkg::GPC_IDLE;
          end else if (expire) begin
            state_next = gpc_pkg::GPC_CONVERT;
          end
        end
        default: state_next = gpc_pkg::GPC_IDLE;
      endcase
    end
  end

  gpc_diff_unit #(
    .SAMPLE_W(SAMPLE_W),
    .CONV_CYCLES(CONV_CYCLES)
  ) u_diff (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_in(launch),
    .abort_in(stop),
    .pos_in(converter_input_pos_in),
    .neg_in(converter_input_neg_in),
    .neg_open_in(neg_open_in),
    .done_out(conv_done),
    .result_out(conv_result)
  );

  // period runs from each launch, so the interval is start to start
  gpc_period_timer #(
    .PERIOD_W(PERIOD_W),
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .restart_in(launch),
    .period_in(period_reg),
    .expire_out(expire)
  );

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= gpc_pkg::GPC_IDLE;
      en_reg <= 1'b0;
      continuous_sampling_bit_reg <= 1'b0;
      busy_reg <= 1'b0;
      pend_reg <= 1'b0;
      period_reg <= gpc_pkg::PERIOD_RST;
      result_reg <= '0;
      rdata_out <= '0;
      status_word_out <= 16'h0000;
      converter_power_out <= 1'b0;
      converter_irq_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      en_reg <= en_next;
      continuous_sampling_bit_reg <= continuous_sampling_bit_next;
      busy_reg <= (state_next == gpc_pkg::GPC_CONVERT);
      pend_reg <= pend_next;
      converter_irq_out <= pend_next;
      converter_power_out <= en_next;
      rdata_out <= rdata_next;
      status_word_out <= status_next;
      if (wr_period) begin
        period_reg <= wdata_in[PERIOD_W-1:0];
      end
      if (conv_done) begin
        result_reg <= conv_result;
      end
    end
  end

  sequence s_launch;
    wr_ctrl && wdata_in[gpc_pkg::CTRL_BUSY_BIT] && wdata_in[gpc_pkg::CTRL_EN_BIT] &&
      state_reg == gpc_pkg::GPC_IDLE;
  endsequence

  sequence s_converting;
    busy_reg [*2];
  endsequence

  sequence s_no_done;
    !conv_done ##1 !conv_done;
  endsequence

  property p_busy_start;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_launch |=> s_converting;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not held after start");

  property p_power;
    @(posedge clk_in) disable iff (!rst_n_in)
      wr_ctrl |=> converter_power_out == $past(wdata_in[gpc_pkg::CTRL_EN_BIT]);
  endproperty
  a_power: assert property (p_power) else $error("power does not follow enable");

  property p_stop;
    @(posedge clk_in) disable iff (!rst_n_in)
      (wr_ctrl && !wdata_in[gpc_pkg::CTRL_EN_BIT]) |=> !busy_reg && state_reg == gpc_pkg::GPC_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("disable did not stop activity");

  property p_done;
    @(posedge clk_in) disable iff (!rst_n_in)
      (conv_done && en_next) |=> converter_irq_out && !busy_reg;
  endproperty
  a_done: assert property (p_done) else $error("completion not flagged");

  property p_read_clear;
    @(posedge clk_in) disable iff (!rst_n_in)
      (rd_result && !conv_done) |=> !converter_irq_out;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("result read kept interrupt");

  property p_set_wins;
    @(posedge clk_in) disable iff (!rst_n_in)
      (rd_result && conv_done) |=> converter_irq_out;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("new completion lost on read");

  property p_continuous_sampling_bit;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state_reg == gpc_pkg::GPC_DONE && continuous_sampling_bit_next && en_next) |=> state_reg == gpc_pkg::GPC_WAIT;
  endproperty
  a_continuous_sampling_bit: assert property (p_continuous_sampling_bit) else $error("continuous mode did not rearm");

  property p_period;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state_reg == gpc_pkg::GPC_WAIT && expire && continuous_sampling_bit_next && en_next) |=> busy_reg;
  endproperty
  a_period: assert property (p_period) else $error("period expiry did not start");

  property p_result;
    @(posedge clk_in) disable iff (!rst_n_in)
      conv_done |=> result_reg == $past(conv_result);
  endproperty
  a_result: assert property (p_result) else $error("result not updated");

  property p_status_pend;
    @(posedge clk_in) disable iff (!rst_n_in)
      long_format_in |=> status_word_out[gpc_pkg::STAT_PEND_BIT] == converter_irq_out;
  endproperty
  a_status_pend: assert property (p_status_pend) else $error("status cell 14 wrong");

  property p_short;
    @(posedge clk_in) disable iff (!rst_n_in)
      !long_format_in |=> status_word_out[15:gpc_pkg::STAT_LONG_LSB] == 8'h00;
  endproperty
  a_short: assert property (p_short) else $error("high status byte in short format");

  property p_start_refused;
    @(posedge clk_in) disable iff (!rst_n_in)
      (wr_ctrl && wdata_in[gpc_pkg::CTRL_BUSY_BIT] && !wdata_in[gpc_pkg::CTRL_EN_BIT]) |=>
        !busy_reg && state_reg == gpc_pkg::GPC_IDLE;
  endproperty
  a_start_refused: assert property (p_start_refused) else $error("start taken without enable");

  property p_irq_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
      (converter_irq_out && !rd_result) |=> converter_irq_out;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without result read");

  property p_irq_quiet;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!converter_irq_out && !conv_done) |=> !converter_irq_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without completion");

  property p_single;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state_reg == gpc_pkg::GPC_DONE && !continuous_sampling_bit_next) |=> state_reg == gpc_pkg::GPC_IDLE && !busy_reg;
  endproperty
  a_single: assert property (p_single) else $error("single conversion repeated");

  property p_wait_quiet;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state_reg == gpc_pkg::GPC_WAIT && !expire) |=> !busy_reg;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("conversion before period expiry");

  property p_abort_quiet;
    @(posedge clk_in) disable iff (!rst_n_in)
      (wr_ctrl && !wdata_in[gpc_pkg::CTRL_EN_BIT]) |=> s_no_done;
  endproperty
  a_abort_quiet: assert property (p_abort_quiet) else $error("completion after disable");

  property p_status_done;
    @(posedge clk_in) disable iff (!rst_n_in)
      (long_format_in && conv_done) |=> status_word_out[gpc_pkg::STAT_PEND_BIT];
  endproperty
  a_status_done: assert property (p_status_done) else $error("completion missing from status");

  property p_result_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
      !conv_done |=> $stable(result_reg);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed without completion");
endmodule : gpc_conversion_control

// ---- gpc_pkg.sv ----
// constants shared by the general purpose converter control block
package gpc_pkg;
  localparam int CLK_NS = 25;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_NS = 2000;
  localparam int CONV_CYCLES = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_W = 12;
  localparam int RESULT_W = SAMPLE_W + 1;
  localparam int PERIOD_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;
  localparam int CTRL_BUSY_BIT = 0;
  localparam int CTRL_CONTINUOUS_SAMPLING_BIT_BIT = 1;
  localparam int CTRL_EN_BIT = 2;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_PEND_BIT = 14;
  localparam int STAT_LONG_LSB = 8;
  localparam logic [SAMPLE_W-1:0] REF_MV = 12'h320;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0001;
  typedef enum logic [1:0] {
    GPC_IDLE = 2'h0,
    GPC_CONVERT = 2'h1,
    GPC_DONE = 2'h3,
    GPC_WAIT = 2'h2
  } gpc_state_t;
endpackage : gpc_pkg

// ---- gpc_period_timer.sv ----
// sampling period timer with its own tick prescaler
`timescale 1ns/1ps
module gpc_period_timer #(
  parameter int PERIOD_W = gpc_pkg::PERIOD_W,
  parameter int TICK_CYCLES = gpc_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic restart_in,
  input wire logic [PERIOD_W-1:0] period_in,
  output logic expire_out
);
  logic [15:0] pre_reg;
  logic [PERIOD_W-1:0] cnt_reg;
  logic tick;
  logic [PERIOD_W-1:0] target;
  assign tick = (pre_reg == 16'(TICK_CYCLES - 1));
  // a zero period is given a target of one tick
  assign target = (period_in == '0) ? PERIOD_W'(1) : period_in;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_reg <= 16'h0000;
      cnt_reg <= '0;
      expire_out <= 1'b0;
    end else begin
      pre_reg <= (restart_in || tick) ? 16'h0000 : pre_reg + 16'h0001;
      expire_out <= 1'b0;
      if (restart_in) begin
        cnt_reg <= '0;
      end else if (tick) begin
        if (cnt_reg + PERIOD_W'(1) >= target) begin
          cnt_reg <= '0;
          expire_out <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + PERIOD_W'(1);
        end
      end
    end
  end
endmodule : gpc_period_timer

// ---- gpc_diff_unit.sv ----
// differential conversion: positive input less negative input or internal reference
`timescale 1ns/1ps
module gpc_diff_unit #(
  parameter int SAMPLE_W = gpc_pkg::SAMPLE_W,
  parameter int CONV_CYCLES = gpc_pkg::CONV_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [SAMPLE_W-1:0] pos_in,
  input wire logic [SAMPLE_W-1:0] neg_in,
  input wire logic neg_open_in,
  output logic done_out,
  output logic [SAMPLE_W:0] result_out
);
  logic [15:0] cnt_reg;
  logic run_reg;
  logic [SAMPLE_W-1:0] neg_sel;
  logic [SAMPLE_W:0] diff;
  assign neg_sel = neg_open_in ? gpc_pkg::REF_MV : neg_in;
  assign diff = {1'b0, pos_in} - {1'b0, neg_sel};

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= 16'h0000;
      run_reg <= 1'b0;
      done_out <= 1'b0;
      result_out <= '0;
    end else begin
      done_out <= 1'b0;
      if (abort_in) begin
        run_reg <= 1'b0;
      end else if (start_in) begin
        run_reg <= 1'b1;
        cnt_reg <= 16'h0000;
      end else if (run_reg) begin
        if (cnt_reg == 16'(CONV_CYCLES - 1)) begin
          run_reg <= 1'b0;
          done_out <= 1'b1;
          result_out <= diff;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end
    end
  end
endmodule : gpc_diff_unit

// ---- gpc_analog_src.sv ----
// analog front model: differential sample codes, negative line floats when open
`timescale 1ns/1ps
module gpc_analog_src (
  input wire logic clk_in,
  input wire logic [11:0] pos_val_in,
  input wire logic [11:0] neg_val_in,
  input wire logic open_in,
  output logic [11:0] pos_out,
  output logic [11:0] neg_out
);
  logic [11:0] float_reg = 12'h000;
  assign pos_out = pos_val_in;
  // open line must not look like a real level: bits where neg_val_in is 0 toggle every cycle
  always @(posedge clk_in) float_reg <= ~float_reg ^ neg_val_in;
  assign neg_out = open_in ? float_reg : neg_val_in;
endmodule : gpc_analog_src

// ---- test_gpc_conversion_control.sv ----
// self-checking bench of the converter control block
`timescale 1ns/1ps
module test_gpc_conversion_control;
  localparam int CONV = 4;
  localparam int TICK = 2;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic neg_open_in = 1'b0;
  logic long_format_in = 1'b0;
  logic [11:0] pos_val = 12'h000;
  logic [11:0] neg_val = 12'h000;
  logic [11:0] pos_w;
  logic [11:0] neg_w;
  logic [15:0] rdata_out;
  logic converter_power_out;
  logic converter_irq_out;
  logic [15:0] status_word_out;
  logic [15:0] rv;
  int mismatches = 0;
  int checks_done = 0;
  int n;
  always #12.5 clk_in = ~clk_in;
  gpc_analog_src src (.clk_in(clk_in), .pos_val_in(pos_val), .neg_val_in(neg_val), .open_in(neg_open_in),
    .pos_out(pos_w), .neg_out(neg_w));
  gpc_conversion_control #(.CONV_CYCLES(CONV), .TICK_CYCLES(TICK)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .converter_input_pos_in(pos_w), .converter_input_neg_in(neg_w), .neg_open_in(neg_open_in),
    .long_format_in(long_format_in), .converter_power_out(converter_power_out),
    .converter_irq_out(converter_irq_out), .status_word_out(status_word_out));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd
  // cycles until interrupt pending, bounded
  task automatic wait_irq(output int cyc);
    cyc = 0;
    while (converter_irq_out !== 1'b1 && cyc < 60) begin
      @(posedge clk_in);
      #1 cyc++;
    end
    if (cyc >= 60) check("irq wait", 16'h0000, 16'h0001);
  endtask : wait_irq
  function automatic logic [15:0] exp_res(input logic [11:0] p, input logic [11:0] q, input logic op);
    logic [12:0] d;
    d = {1'b0, p} - {1'b0, (op ? 12'h320 : q)};
    return {{3{d[12]}}, d};
  endfunction : exp_res
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  initial begin
    #(25 * 20000);
    mismatches++;
    close_out();
  end
  initial begin
    void'($urandom(32'h639D));
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(4'h0, rv);
    check("ctrl reset", rv, 16'h0000);
    rd(4'h9, rv);
    check("unmapped read", rv, 16'h0000);
    rd(4'h1, rv);
    check("period reset", rv, 16'h0001);
    @(posedge clk_in);
    #1 check("read data after slot", rdata_out, 16'h0000);
    wr(4'h0, 16'h0001);
    rd(4'h0, rv);
    check("start without enable", rv, 16'h0000);
    $display("test reset and refusal done");
    for (int i = 0; i < 6; i++) begin
      pos_val <= (i == 0) ? 12'h000 : 12'(($urandom % 16'h0FFF));
      neg_val <= (i == 1) ? 12'hFFF : 12'($urandom);
      neg_open_in <= (i % 3) == 2;
      long_format_in <= i[0];
      wr(4'h0, 16'h0005);
      #1 check("power", {15'h0, converter_power_out}, 16'h0001);
      rd(4'h0, rv);
      check("busy while converting", rv, 16'h0005);
      wait_irq(n);
      rd(4'h0, rv);
      check("busy after done", rv, 16'h0004);
      check("status pending", {status_word_out[15], status_word_out[14], status_word_out[13:0]},
        long_format_in ? 16'h4001 : 16'h0001);
      rd(4'h2, rv);
      check("result", rv, exp_res(pos_val, neg_val, neg_open_in));
      #1 check("irq cleared", {15'h0, converter_irq_out}, 16'h0000);
    end
    $display("test single conversions done");
    wr(4'h1, 16'h0005);
    wr(4'h0, 16'h0007);
    wait_irq(n);
    rd(4'h2, rv);
    wait_irq(n);
    // read took two cycles after the first completion; expiry is registered, one cycle past the last tick
    check("period spacing", 16'(n + 2), 16'(5 * TICK + 1));
    pos_val <= 12'h123;
    rd(4'h2, rv);
    wait_irq(n);
    rd(4'h2, rv);
    check("continuous result", rv, exp_res(12'h123, neg_val, neg_open_in));
    $display("test continuous done");
    // leave continuous mode first, so the start below is taken while idle
    wr(4'h0, 16'h0004);
    wr(4'h0, 16'h0005);
    wr(4'h0, 16'h0000);
    repeat (CONV + 4) @(posedge clk_in);
    #1 check("irq after abort", {15'h0, converter_irq_out}, 16'h0000);
    check("power after abort", {15'h0, converter_power_out}, 16'h0000);
    rd(4'h0, rv);
    check("ctrl after abort", rv, 16'h0000);
    $display("test abort done");
    close_out();
  end
endmodule : test_gpc_conversion_control
